// >>> pkg/wtp_consts.svh
// constants for the watchpoint trace and performance channel block
// assumes inclusion by bare name from design files
`ifndef WTP_CONSTS_SVH
`define WTP_CONSTS_SVH

// register offsets (byte addresses)
`define WTP_OFS_BR_FILTER   8'h00
`define WTP_OFS_FPF_PRE     8'h04
`define WTP_OFS_TRCTL       8'h08
`define WTP_OFS_PERF0_LO    8'h0c
`define WTP_OFS_PERF0_HI    8'h10
`define WTP_OFS_PERF1_LO    8'h14
`define WTP_OFS_PERF1_HI    8'h18
`define WTP_OFS_PCOUNT0     8'h1c
`define WTP_OFS_PCOUNT1     8'h20
`define WTP_OFS_STATUS      8'h24
`define WTP_OFS_FPF         8'h28

// branch filter fields
`define WTP_BF_ENABLE       0
`define WTP_BF_SPACE_EN     1
`define WTP_BF_CHAIN_EN     2
`define WTP_BF_CHAIN_LO     3
`define WTP_BF_CHAIN_HI     6
`define WTP_BF_SPACE_LO     7
`define WTP_BF_SPACE_HI     14
`define WTP_BF_MD_LO        15
`define WTP_BF_MD_HI        16
`define WTP_BF_COND         17
`define WTP_BF_UNCOND       18
`define WTP_BF_RTE          19
`define WTP_BF_EVENT        20
`define WTP_BF_TIMESTAMP    21
`define WTP_BF_TRIG_OUT     22
`define WTP_BF_MASK         32'h007f_ffff

// trace control fields
`define WTP_TC_HOLD         0
`define WTP_TC_THRESH       1

// perf match bits
`define WTP_PM_ITLB         0
`define WTP_PM_ICACHE       1

// address steps and debug vector
`define WTP_STEP_WIDE       64'h4
`define WTP_STEP_COMPACT    64'h2
`define WTP_VEC_FIFO        32'h0000_0200
`define WTP_PERF_LAT        2
`define WTP_ZERO32          32'h0000_0000

`endif

// >>> pkg/wtp_pkg.sv
// types for the watchpoint trace and performance channel block
// assumes wtp_consts.svh is compiled alongside
package wtp_pkg;

  typedef enum logic [1:0] {
    WTP_BR_BRANCH_COND,
    WTP_BR_BRANCH_UNCOND,
    WTP_BR_RTE,
    WTP_BR_EVENT
  } wtp_br_type_t;

  // one retired control-flow step reported by the core
  typedef struct packed {
    logic        valid;
    logic        is_cond;     // conditional branch
    logic        is_uncond;   // unconditional branch
    logic        is_rte;      // return from exception
    logic        excepts;     // destination (or self) excepted
    logic        self_exc;    // no jump: plain exception at pc
    logic        slot_exc;    // delay slot excepted
    logic        delayed;     // compact delayed branch
    logic        compact;     // compact_instruction_mode of pc
    logic        dst_compact; // mode of destination
    logic        watch_before;
    logic        watch_after;
    logic [1:0]  md_pc;       // privilege mode at pc
    logic [1:0]  md_dst;      // privilege mode at destination
    logic [63:0] pc;
    logic [63:0] dst;
    logic [63:0] handler;
  } wtp_flow_t;

  typedef struct packed {
    logic         valid;
    wtp_br_type_t kind;
    logic         timestamp;
    logic [63:0]  src;
    logic [63:0]  dst;
  } wtp_trace_t;

  typedef struct packed {
    logic        instr_tlb_miss_select;
    logic        icache_hit;
    logic        prefetch;
    logic        wp_hit;
    logic        wp_pcount;
    logic        wp_sel;
    logic        pre_ok;
  } wtp_perf_ev_t;

endpackage

// >>> rtl/wtp_perf_chan.sv
// one performance counter channel with fixed latency increment
// assumes synchronous core event pulses on clk
`timescale 1ns/1ps
`default_nettype none
`include "wtp_consts.svh"

module wtp_perf_chan
  import wtp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [63:0] match_sel,
  input  wire wtp_perf_ev_t ev,
  input  wire logic        watch_en,
  input  wire logic        wr_cnt,
  input  wire logic [31:0] wr_data,
  output logic      [31:0] count
);

  logic                      hit;
  logic [`WTP_PERF_LAT-1:0]  pipe_reg;
  logic [31:0]               count_reg;

  // core events or watchpoint hits, ORed into one increment
  assign hit = watch_en & (
    (ev.wp_hit & ev.wp_pcount & ev.wp_sel) |
    (ev.pre_ok & match_sel[`WTP_PM_ITLB] & ev.instr_tlb_miss_select) |
    (ev.pre_ok & match_sel[`WTP_PM_ICACHE] & ev.icache_hit
      & ~ev.prefetch));
  assign count = count_reg;

  // fixed delay line keeps event spacing observable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe_reg  <= '0;
      count_reg <= `WTP_ZERO32;
    end else begin
      pipe_reg  <= {pipe_reg[`WTP_PERF_LAT-2:0], hit};
      if (wr_cnt)
        count_reg <= wr_data;
      else if (pipe_reg[`WTP_PERF_LAT-1])
        count_reg <= count_reg + 32'h1;
    end
  end

endmodule // wtp_perf_chan
`default_nettype wire

// >>> rtl/wtp_br_addr.sv
// branch trace source/destination selection, combinational
// assumes one flow record per cycle from the retire stage
`timescale 1ns/1ps
`default_nettype none
`include "wtp_consts.svh"

module wtp_br_addr
  import wtp_pkg::*;
(
  input  wire wtp_flow_t   flow,
  output logic [63:0]      first_src,
  output logic [63:0]      first_dst,
  output logic [63:0]      event_src,
  output logic             has_first
);

  // mark mode in lsb: wide set, compact clear
  function automatic logic [63:0] tag(input logic [63:0] a,
                                      input logic cmp);
    tag = {a[63:1], ~cmp};
  endfunction

  logic [63:0] branch_src;
  logic [63:0] self_src;

  // delayed compact branches report the slot address
  assign branch_src = (flow.compact & flow.delayed) ?
                      flow.pc + `WTP_STEP_COMPACT : flow.pc;
  // plain exception: last completed instruction before pc
  assign self_src = flow.compact ? flow.pc - `WTP_STEP_COMPACT
                                 : flow.pc - `WTP_STEP_WIDE;

  assign has_first = ~flow.self_exc;
  assign first_src = tag(flow.is_rte ? flow.pc : branch_src,
                         flow.compact);
  assign first_dst = tag(flow.dst, flow.dst_compact);
  // self_exc with slot_exc: compact branch slot excepted, source X
  assign event_src =
    flow.self_exc ? (flow.slot_exc ? tag(flow.pc, flow.compact)
                     : tag(self_src, flow.compact)) :
    (flow.is_rte & flow.slot_exc) ? tag(flow.dst, 1'b1) :
    flow.is_rte ? tag(flow.pc, flow.compact) :
    tag(branch_src, flow.compact);

endmodule // wtp_br_addr
`default_nettype wire

// >>> rtl/wtp_chan_top.sv
// watchpoint branch, flag-post, fifo and perf channels
// assumes core events are single-cycle and synchronous to clk
// Behaviour
// - branch channel always emits trace on trigger; a trigger in the cycle after a two-trigger step is dropped
// - event trace checks mode of interrupted instruction
// - return trace checks mode after return
// - source is last completed instruction before jump
// - compact delayed branch source is X+2
// - return then event trigger if Y excepts
// - plain exception source X-4 or X-2
// - excepting branch target gives branch then event
// - compact branch or slot exception sources
// - return to excepting compact branch sources
// - address lsb marks wide versus compact mode
// - flag post write triggers trace regardless watch
// - flag post precondition honours enable, space, chain
// - fifo hold writes trigger regardless of watch
// - threshold selects every write or high-water
// - fifo interrupt vector 0x200, sets cause bit
// - perf counter counts hits and selected events
// - one increment per cycle, fixed latency
// - perf channels silent while watch flag zero
// - match bit0 tlb miss, bit1 cache hits
// - filter bits 17 to 20 select branch kinds
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "wtp_consts.svh"

module wtp_chan_top
  import wtp_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [31:0]  reg_rdata,
  input  wire wtp_flow_t    flow,
  input  wire logic         watch_enable_flag,
  input  wire logic [7:0]   cur_space_id,
  input  wire logic [15:0]  chain_latches,
  input  wire logic         flag_post_wr,
  input  wire logic [63:0]  flag_post_pc,
  input  wire logic         fifo_wr,
  input  wire logic         fifo_high_water,
  input  wire wtp_perf_ev_t perf_ev0,
  input  wire wtp_perf_ev_t perf_ev1,
  output wtp_trace_t        br_trace,
  output logic              br_trig_out,
  output wtp_trace_t        fpf_trace,
  output logic              dm_trigger,
  output logic              debug_interrupt_event,
  output logic      [31:0]  debug_vector_offset,
  output logic              fifo_interrupt_cause
);

  ////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] filter_reg;
  logic [31:0] fpf_pre_reg;
  logic [1:0]  trctl_reg;
  logic [63:0] perf_sel_reg [2];
  logic        cause_reg;
  logic [63:0] fpf_data_reg;
  logic [31:0] rdata_reg;
  logic [31:0] pcount [2];

  // write strobes decoded once
  logic wr_filter;
  logic wr_fpf_pre;
  logic wr_trctl;
  logic wr_status;
  logic wr_fpf;
  logic [3:0] wr_perf;
  logic [1:0] wr_cnt;

  assign wr_filter  = reg_wr & (reg_addr == `WTP_OFS_BR_FILTER);
  assign wr_fpf_pre = reg_wr & (reg_addr == `WTP_OFS_FPF_PRE);
  assign wr_trctl   = reg_wr & (reg_addr == `WTP_OFS_TRCTL);
  assign wr_status  = reg_wr & (reg_addr == `WTP_OFS_STATUS);
  assign wr_fpf     = reg_wr & (reg_addr == `WTP_OFS_FPF);
  assign wr_perf[0] = reg_wr & (reg_addr == `WTP_OFS_PERF0_LO);
  assign wr_perf[1] = reg_wr & (reg_addr == `WTP_OFS_PERF0_HI);
  assign wr_perf[2] = reg_wr & (reg_addr == `WTP_OFS_PERF1_LO);
  assign wr_perf[3] = reg_wr & (reg_addr == `WTP_OFS_PERF1_HI);
  assign wr_cnt[0]  = reg_wr & (reg_addr == `WTP_OFS_PCOUNT0);
  assign wr_cnt[1]  = reg_wr & (reg_addr == `WTP_OFS_PCOUNT1);

  // software-visible configuration; reserved filter bits stay zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_reg   <= `WTP_ZERO32;
      fpf_pre_reg  <= `WTP_ZERO32;
      trctl_reg    <= 2'h0;
      fpf_data_reg <= 64'h0;
    end else begin
      if (wr_filter)
        filter_reg <= reg_wdata & `WTP_BF_MASK;
      if (wr_fpf_pre)
        fpf_pre_reg <= reg_wdata;
      if (wr_trctl)
        trctl_reg <= reg_wdata[1:0];
      if (wr_fpf)
        fpf_data_reg <= {32'h0, reg_wdata};
    end
  end

  // perf match select words, one per channel, low/high halves
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sel
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          perf_sel_reg[g] <= 64'h0;
        else if (wr_perf[2*g])
          perf_sel_reg[g][31:0] <= reg_wdata;
        else if (wr_perf[2*g+1])
          perf_sel_reg[g][63:32] <= reg_wdata;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // branch channel

  logic [63:0] first_src;
  logic [63:0] first_dst;
  logic [63:0] event_src;
  logic        has_first;

  wtp_br_addr u_addr (
    .flow      (flow),
    .first_src (first_src),
    .first_dst (first_dst),
    .event_src (event_src),
    .has_first (has_first)
  );

  // mode match: select bit n admits the modes whose md bit0 equals n; a zero select admits all
  function automatic logic md_ok(input logic [1:0] sel,
                                 input logic [1:0] md);
    md_ok = (sel == 2'h0) | sel[md[0]];
  endfunction

  // shared space-id and chain precondition check
  function automatic logic pre_ok(input logic [31:0] r,
                                  input logic [7:0]  sid,
                                  input logic [15:0] chains);
    pre_ok = r[`WTP_BF_ENABLE] &
      (~r[`WTP_BF_SPACE_EN] |
        (r[`WTP_BF_SPACE_HI:`WTP_BF_SPACE_LO] == sid)) &
      (~r[`WTP_BF_CHAIN_EN] |
        chains[r[`WTP_BF_CHAIN_HI:`WTP_BF_CHAIN_LO]]);
  endfunction

  logic [1:0]  md_sel;
  logic        br_pre;
  logic        kind_en;
  logic        watch_ok;
  logic        md_match;
  logic        br_fire;
  logic        ev_fire;
  logic        ev_pending_reg;
  logic [63:0] ev_src_reg;
  logic [63:0] ev_dst_reg;
  wtp_trace_t  br_trace_reg;
  wtp_br_type_t first_kind;

  assign md_sel = filter_reg[`WTP_BF_MD_HI:`WTP_BF_MD_LO];
  assign br_pre = pre_ok(filter_reg, cur_space_id, chain_latches);
  assign first_kind = flow.is_rte ? WTP_BR_RTE :
                      flow.is_cond ? WTP_BR_BRANCH_COND :
                      WTP_BR_BRANCH_UNCOND;
  assign kind_en = (flow.is_cond & filter_reg[`WTP_BF_COND]) |
                   (flow.is_uncond & filter_reg[`WTP_BF_UNCOND]) |
                   (flow.is_rte & filter_reg[`WTP_BF_RTE]);
  // returns need watch on both sides, branches at the destination
  assign watch_ok = flow.is_rte ?
                    (flow.watch_before & flow.watch_after) :
                    flow.watch_after;
  // returns compare against the first instruction after the return
  assign md_match = flow.is_rte ? md_ok(md_sel, flow.md_dst)
                                : md_ok(md_sel, flow.md_pc);
  assign br_fire = flow.valid & has_first & br_pre & kind_en &
                   watch_ok & md_match;
  // event check uses mode of the excepting instruction
  assign ev_fire = flow.valid & flow.excepts & br_pre &
                   filter_reg[`WTP_BF_EVENT] & flow.watch_after &
                   md_ok(md_sel, flow.self_exc ? flow.md_pc
                                               : flow.md_dst);

  // two-trigger scenarios: first trigger now, event next cycle;
  // a trigger from a new flow in that cycle is dropped here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      br_trace_reg   <= '0;
      ev_pending_reg <= 1'b0;
      ev_src_reg     <= 64'h0;
      ev_dst_reg     <= 64'h0;
    end else begin
      br_trace_reg.valid     <= 1'b0;
      br_trace_reg.timestamp <= filter_reg[`WTP_BF_TIMESTAMP];
      ev_pending_reg         <= 1'b0;
      if (ev_pending_reg) begin
        br_trace_reg.valid <= 1'b1;
        br_trace_reg.kind  <= WTP_BR_EVENT;
        br_trace_reg.src   <= ev_src_reg;
        br_trace_reg.dst   <= ev_dst_reg;
      end else if (br_fire) begin
        br_trace_reg.valid <= 1'b1;
        br_trace_reg.kind  <= first_kind;
        br_trace_reg.src   <= first_src;
        br_trace_reg.dst   <= first_dst;
        ev_pending_reg     <= ev_fire;
      end else if (ev_fire) begin
        br_trace_reg.valid <= 1'b1;
        br_trace_reg.kind  <= WTP_BR_EVENT;
        br_trace_reg.src   <= event_src;
        br_trace_reg.dst   <= {flow.handler[63:1], 1'b1};
      end
      if (br_fire & ev_fire & ~ev_pending_reg) begin
        ev_src_reg <= event_src;
        ev_dst_reg <= {flow.handler[63:1], 1'b1};
      end
    end
  end

  assign br_trace    = br_trace_reg;
  assign br_trig_out = br_trace_reg.valid & filter_reg[`WTP_BF_TRIG_OUT];

  ////////////////////////////////////////////////////////////////////
  // flag post channel: no watch gating, no event count fields

  wtp_trace_t fpf_trace_reg;
  logic       fpf_fire;

  assign fpf_fire = flag_post_wr &
                    pre_ok(fpf_pre_reg, cur_space_id, chain_latches);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      fpf_trace_reg <= '0;
    else begin
      fpf_trace_reg.valid     <= fpf_fire;
      fpf_trace_reg.kind      <= WTP_BR_EVENT;
      fpf_trace_reg.timestamp <= 1'b0;
      fpf_trace_reg.src       <= flag_post_pc;
      fpf_trace_reg.dst       <= fpf_data_reg;
    end
  end

  assign fpf_trace = fpf_trace_reg;

  ////////////////////////////////////////////////////////////////////
  // debug module fifo channel

  logic dm_fire;
  logic int_fire;
  logic dm_trig_reg;
  logic int_reg;

  assign dm_fire  = trctl_reg[`WTP_TC_HOLD] & fifo_wr;
  assign int_fire = trctl_reg[`WTP_TC_THRESH] ? fifo_high_water
                                              : fifo_wr;

  // cause bit: hardware set wins over a software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dm_trig_reg <= 1'b0;
      int_reg     <= 1'b0;
      cause_reg   <= 1'b0;
    end else begin
      dm_trig_reg <= dm_fire;
      int_reg     <= int_fire;
      cause_reg   <= int_fire | (cause_reg & ~(wr_status &
                     reg_wdata[0]));
    end
  end

  assign dm_trigger            = dm_trig_reg;
  assign debug_interrupt_event = int_reg;
  assign debug_vector_offset   = `WTP_VEC_FIFO;
  assign fifo_interrupt_cause  = cause_reg;

  ////////////////////////////////////////////////////////////////////
  // performance counter channels; channel n feeds counter n

  wtp_perf_chan u_perf0 (
    .clk       (clk),
    .rst_n     (rst_n),
    .match_sel (perf_sel_reg[0]),
    .ev        (perf_ev0),
    .watch_en  (watch_enable_flag),
    .wr_cnt    (wr_cnt[0]),
    .wr_data   (reg_wdata),
    .count     (pcount[0])
  );

  wtp_perf_chan u_perf1 (
    .clk       (clk),
    .rst_n     (rst_n),
    .match_sel (perf_sel_reg[1]),
    .ev        (perf_ev1),
    .watch_en  (watch_enable_flag),
    .wr_cnt    (wr_cnt[1]),
    .wr_data   (reg_wdata),
    .count     (pcount[1])
  );

  ////////////////////////////////////////////////////////////////////
  // read path, data one cycle after the strobe; unmapped reads zero

  logic [31:0] rd_mux;

  assign rd_mux =
    (reg_addr == `WTP_OFS_BR_FILTER) ? filter_reg :
    (reg_addr == `WTP_OFS_FPF_PRE)   ? fpf_pre_reg :
    (reg_addr == `WTP_OFS_TRCTL)     ? {30'h0, trctl_reg} :
    (reg_addr == `WTP_OFS_PERF0_LO)  ? perf_sel_reg[0][31:0] :
    (reg_addr == `WTP_OFS_PERF0_HI)  ? perf_sel_reg[0][63:32] :
    (reg_addr == `WTP_OFS_PERF1_LO)  ? perf_sel_reg[1][31:0] :
    (reg_addr == `WTP_OFS_PERF1_HI)  ? perf_sel_reg[1][63:32] :
    (reg_addr == `WTP_OFS_PCOUNT0)   ? pcount[0] :
    (reg_addr == `WTP_OFS_PCOUNT1)   ? pcount[1] :
    (reg_addr == `WTP_OFS_STATUS)    ? {31'h0, cause_reg} :
    (reg_addr == `WTP_OFS_FPF)       ? fpf_data_reg[31:0] :
    `WTP_ZERO32;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rdata_reg <= `WTP_ZERO32;
    else
      rdata_reg <= reg_rd ? rd_mux : `WTP_ZERO32;
  end

  assign reg_rdata = rdata_reg;

endmodule // wtp_chan_top
`default_nettype wire

// >>> verif/wtp_chan_monitor.sv
// checker tying block outputs to their causes at the inputs
// assumes a bind onto wtp_chan_top, one clock, reset active low
`timescale 1ns/1ps
`default_nettype none
module wtp_chan_monitor
  import wtp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire wtp_flow_t   flow,
  input wire logic        flag_post_wr,
  input wire logic [63:0] flag_post_pc,
  input wire logic        fifo_wr,
  input wire logic        fifo_high_water,
  input wire wtp_trace_t  br_trace,
  input wire logic        br_trig_out,
  input wire wtp_trace_t  fpf_trace,
  input wire logic        dm_trigger,
  input wire logic        debug_interrupt_event,
  input wire logic [31:0] debug_vector_offset,
  input wire logic        fifo_interrupt_cause
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // each pulse answers a cause one edge back; a pending event trace answers a flow step two edges back
  a_vec_fixed:
    assert property (debug_vector_offset == 32'h0000_0200)
    else $error("vector offset wrong");
  a_int_cause:
    assert property (debug_interrupt_event |-> fifo_interrupt_cause)
    else $error("interrupt without cause bit");
  a_int_source:
    assert property (debug_interrupt_event |-> $past(fifo_wr | fifo_high_water))
    else $error("interrupt without fifo activity");
  a_dm_source:
    assert property (dm_trigger |-> $past(fifo_wr))
    else $error("fifo trigger without a write");
  a_fpf_source:
    assert property (fpf_trace.valid |->
      $past(flag_post_wr) && fpf_trace.src == $past(flag_post_pc))
    else $error("flag post trace without store");
  a_trig_gated:
    assert property (br_trig_out |-> br_trace.valid)
    else $error("trigger out without trace");
  a_br_source:
    assert property (br_trace.valid |-> $past(flow.valid) || $past(flow.valid, 2))
    else $error("branch trace without a flow step");
  a_event_second:
    assert property ($past(br_trace.valid) && br_trace.valid && !$past(flow.valid)
      |-> br_trace.kind == WTP_BR_EVENT)
    else $error("second trigger is not an event");
  // main scenarios reached
  c_event: cover property (br_trace.valid && br_trace.kind == WTP_BR_EVENT);
  c_dm: cover property (dm_trigger);
  c_fpf: cover property (fpf_trace.valid);
endmodule // wtp_chan_monitor
bind wtp_chan_top wtp_chan_monitor i_mon (.clk, .rst_n, .flow, .flag_post_wr,
  .flag_post_pc, .fifo_wr, .fifo_high_water, .br_trace, .br_trig_out,
  .fpf_trace, .dm_trigger, .debug_interrupt_event, .debug_vector_offset,
  .fifo_interrupt_cause);
`default_nettype wire

// >>> verif/wtp_core_model.sv
// core pipeline and fifo side: retired steps and sideband pulses
// assumes calls from the bench; each pulse lasts one clock
`timescale 1ns/1ps
`default_nettype none
module wtp_core_model
  import wtp_pkg::*;
(
  input  wire logic     clk,
  output wtp_flow_t     flow,
  output logic          flag_post_wr,
  output logic [63:0]   flag_post_pc,
  output logic          fifo_wr,
  output logic          fifo_high_water,
  output wtp_perf_ev_t  perf_ev0,
  output wtp_perf_ev_t  perf_ev1
);
  // idle at time zero
  initial begin
    {flow, flag_post_wr, fifo_wr, fifo_high_water} = '0;
    {flag_post_pc, perf_ev0, perf_ev1} = '0;
  end
  // one retired step; stale fields scrambled after it
  task automatic step(input wtp_flow_t f);
    @(posedge clk);
    flow <= f;
    @(posedge clk);
    flow <= {1'b0, ~f[$bits(wtp_flow_t)-2:0]};
  endtask
  // w: bit0 flag post store, bit1 fifo write, bit2 high-water
  task automatic side(input logic [2:0] w, input wtp_perf_ev_t e0, e1,
                      input logic [63:0] pc);
    @(posedge clk);
    {fifo_high_water, fifo_wr, flag_post_wr} <= w;
    perf_ev0 <= e0;
    perf_ev1 <= e1;
    flag_post_pc <= pc;
    @(posedge clk);
    {fifo_high_water, fifo_wr, flag_post_wr, perf_ev0, perf_ev1} <= '0;
    flag_post_pc <= ~pc; // sync gap
  endtask
endmodule // wtp_core_model
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the watchpoint channel block
// assumes the core model drives every event input of the block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import wtp_pkg::*;
;
  typedef struct packed {
    logic [8:0]   f;
    wtp_br_type_t k;
    logic [15:0]  s1, d1, s2;
  } wtp_tb_row_t;
  logic         clk, rst_n, reg_wr, reg_rd, watch;
  logic         fpw, fw, fhw, trig_out, dm_trig, dbg_int, cause;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata, rd_val, vec;
  logic [31:0]  cnt [2];
  logic [63:0]  fpc;
  wtp_flow_t    flow, f;
  wtp_perf_ev_t ev0, ev1;
  wtp_trace_t   br, fpf;
  int           num_errors, total_checks, cycles;
  logic [31:0]  fpre [4] = '{32'h1, 32'h883, 32'h2d03, 32'h0};
  logic [6:0]   ff [4] = '{7'h2b, 7'h30, 7'h48, 7'h51};
  logic [9:0]   pf [7] = '{10'h2c1, 10'h2cf, 10'h28e, 10'h331, 10'h3a1,
                           10'h041, 10'h221};
  // flags {cond,uncond,rte,exc,self,slot,dly,cmp,dcmp}; pc 1000 dst 2000
  wtp_tb_row_t  rows [13] = '{
    '{9'h080, WTP_BR_BRANCH_UNCOND, 16'h1001, 16'h2001, 16'h0},
    '{9'h103, WTP_BR_BRANCH_COND, 16'h1000, 16'h2000, 16'h0},
    '{9'h107, WTP_BR_BRANCH_COND, 16'h1002, 16'h2000, 16'h0},
    '{9'h040, WTP_BR_RTE, 16'h1001, 16'h2001, 16'h0},
    '{9'h060, WTP_BR_RTE, 16'h1001, 16'h2001, 16'h1001},
    '{9'h030, WTP_BR_EVENT, 16'h0ffd, 16'h3001, 16'h0},
    '{9'h033, WTP_BR_EVENT, 16'h0ffe, 16'h3001, 16'h0},
    '{9'h0a0, WTP_BR_BRANCH_UNCOND, 16'h1001, 16'h2001, 16'h1001},
    '{9'h127, WTP_BR_BRANCH_COND, 16'h1002, 16'h2000, 16'h1002},
    '{9'h133, WTP_BR_EVENT, 16'h0ffe, 16'h3001, 16'h0},
    '{9'h0bf, WTP_BR_EVENT, 16'h1000, 16'h3001, 16'h0},
    '{9'h061, WTP_BR_RTE, 16'h1001, 16'h2000, 16'h1001},
    '{9'h069, WTP_BR_RTE, 16'h1001, 16'h2000, 16'h2000}};
  ////////////////////////////////////////////////////////////////////////
  wtp_core_model i_core (.clk, .flow, .flag_post_wr(fpw),
    .flag_post_pc(fpc), .fifo_wr(fw), .fifo_high_water(fhw),
    .perf_ev0(ev0), .perf_ev1(ev1));
  wtp_chan_top i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .flow, .watch_enable_flag(watch),
    .cur_space_id(8'h5a), .chain_latches(16'h0000), .flag_post_wr(fpw),
    .flag_post_pc(fpc), .fifo_wr(fw), .fifo_high_water(fhw),
    .perf_ev0(ev0), .perf_ev1(ev1), .br_trace(br), .br_trig_out(trig_out),
    .fpf_trace(fpf), .dm_trigger(dm_trig), .debug_interrupt_event(dbg_int),
    .debug_vector_offset(vec), .fifo_interrupt_cause(cause));
  ////////////////////////////////////////////////////////////////////////
  // 40 MHz clock; hang guard well above the expected run
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic check(input logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // register bus: one-cycle strobes, read data a cycle later
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, watch, reg_addr, reg_wdata} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h24);
    check({vec, rd_val}, {32'h200, 32'h0});
    rd(8'h3c);
    check(rd_val, 32'h0);
    wr(8'h00, 32'hff80_0000);
    rd(8'h00);
    check(rd_val, 32'h0);
    wr(8'h00, 32'h005e_0001);
    // table of branch, return and exception steps
    foreach (rows[i]) begin
      f = '0;
      {f.is_cond, f.is_uncond, f.is_rte, f.excepts, f.self_exc,
       f.slot_exc, f.delayed, f.compact, f.dst_compact} = rows[i].f;
      {f.valid, f.watch_before, f.watch_after} = 3'b111;
      {f.pc, f.dst, f.handler} = {64'h1000, 64'h2000, 64'h3000};
      i_core.step(f);
      #1 check({br.valid, trig_out, br.kind, br.src[15:0], br.dst[15:0]},
        {2'b11, rows[i].k, rows[i].s1, rows[i].d1});
      @(posedge clk);
      #1 check(br.valid ? {1'b1, br.kind, br.src[15:0], br.dst[15:0]} : 35'h0,
        rows[i].s2 ? {1'b1, WTP_BR_EVENT, rows[i].s2, 16'h3001}
                   : 35'h0);
    end
    $display("branch table done");
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h005e_8001);
    // mode select admits md bit0 clear only: events then returns
    for (int j = 0; j < 4; j++) begin
      f = '0;
      {f.valid, f.watch_before, f.watch_after} = 3'b111;
      {f.is_rte, f.excepts, f.self_exc} = j[1] ? 3'b100 : 3'b011;
      f.md_pc = {1'b0, j[1] ^ j[0]};
      f.md_dst = {1'b0, ~(j[1] ^ j[0])};
      i_core.step(f);
      #1 check(br.valid, !j[0]);
      @(posedge clk);
    end
    $display("mode filter done");
    // flag post, watch low; rewrite only while disabled
    foreach (fpre[k]) begin
      wr(8'h04, 32'h0);
      wr(8'h04, fpre[k]);
      i_core.side(3'b001, '0, '0, 64'h4001);
      #1 check(fpf.valid ? fpf.src : 64'h0,
        (k == 0 || k == 2) ? 64'h4001 : 64'h0);
    end
    // fifo rows {control, pulses, trigger, interrupt}
    foreach (ff[k]) begin
      wr(8'h08, {30'h0, ff[k][6:5]});
      i_core.side(ff[k][4:2], '0, '0, 64'h0);
      #1 check({dm_trig, dbg_int}, ff[k][1:0]);
    end
    rd(8'h24);
    check(rd_val, 32'h1);
    wr(8'h24, 32'h1);
    rd(8'h24);
    check(rd_val, 32'h0);
    $display("flag post and fifo done");
    // perf rows {watch, channel, increment, event bits}
    wr(8'h0c, 32'h1);
    wr(8'h14, 32'h2);
    wr(8'h1c, 32'h0);
    wr(8'h20, 32'h0);
    cnt = '{32'h0, 32'h0};
    foreach (pf[k]) begin
      @(posedge clk);
      watch <= pf[k][9];
      i_core.side(3'b000, pf[k][8] ? 7'h00 : pf[k][6:0],
        pf[k][8] ? pf[k][6:0] : 7'h00, 64'h0);
      repeat (3) @(posedge clk);
      cnt[pf[k][8]] += {31'h0, pf[k][7]};
      rd(pf[k][8] ? 8'h20 : 8'h1c);
      check(rd_val, cnt[pf[k][8]]);
    end
    $display("perf counters done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
